// ==== hdl/mmd_pkg.sv ====
// constants and carrier types for the memory map decoder
package mmd_pkg;
   // ----------------------------------------------------------------
   // widths and program vectors
   // ----------------------------------------------------------------
   localparam int          PC_W      = 13;
   localparam int          PROG_AW   = 11;
   localparam int          INSN_W    = 14;
   localparam int          DATA_W    = 8;
   localparam int          DADDR_W   = 8;
   localparam int          DIR_W     = 7;
   localparam int          RAM_WORDS = 128;
   localparam logic [12:0] RESET_VEC = 13'h0000;
   localparam logic [12:0] INT_VEC   = 13'h0004;
   localparam logic [13:0] INSN_RST  = 14'h0000;
   localparam logic [7:0]  RDATA_RST = 8'h00;
   // ----------------------------------------------------------------
   // data map boundaries
   // ----------------------------------------------------------------
   localparam logic [6:0]  SFR_SPAN  = 7'h20;
   localparam logic [6:0]  GPR0_BASE = 7'h20;
   localparam logic [7:0]  GPR1_HI   = 8'hBF;
   localparam logic [7:0]  MIRROR_LO = 8'hF0;
   localparam logic [7:0]  BANK_STEP = 8'h80;
   localparam logic [6:0]  GPR1_OFS  = 7'h40;

   typedef enum logic [1:0] {
      MMD_SFR  = 2'b00,
      MMD_GPR  = 2'b01,
      MMD_NONE = 2'b11
   } mmd_kind_t;

   typedef struct packed {
      mmd_kind_t  kind;
      logic [6:0] idx;
   } mmd_dec_t;

   typedef struct packed {
      logic       valid;
      logic       we;
      logic       indirect;
      logic [6:0] dir_addr;
      logic [7:0] wdata;
   } mmd_req_t;

   typedef struct packed {
      logic       sel;
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mmd_sfr_t;

   typedef struct packed {
      logic       valid;
      logic       special_function_regs;
      logic [7:0] data;
   } mmd_rd_t;
endpackage : mmd_pkg

// ==== hdl/mmd_decoder.sv ====
// program counter, program store and data memory map decoder
`timescale 1ns/10ps
module mmd_decoder #(
   parameter int PROG_WORDS = 2048
) (
   input  wire logic                  clk,        // core clock, 20 MHz
   input  wire logic                  reset,      // sync, active high
   input  wire logic                  pc_step,    // advance one word
   input  wire logic                  pc_jump,    // load jump target
   input  wire logic [12:0]           pc_target,  // jump target
   input  wire logic                  int_take,   // interrupt taken
   input  wire logic                  pgm_we,     // program store write
   input  wire logic [10:0]           pgm_addr,   // program store addr
   input  wire logic [13:0]           pgm_wdata,  // program word
   input  wire mmd_pkg::mmd_req_t     req,        // data access request
   input  wire logic                  bank_select_bit,   // status bank
   input  wire logic                  upper_bank_bit,    // reserved
   input  wire logic                  indirect_page_bit, // reserved
   input  wire logic [7:0]            indirect_address_pointer, // ptr
   output logic [12:0]                pc,         // program counter
   output logic [10:0]                prog_addr,  // physical fetch addr
   output logic [13:0]                instr,      // fetched word
   output logic [7:0]                 data_addr,  // resolved address
   output mmd_pkg::mmd_sfr_t          special_function_regs,        // special reg access
   output mmd_pkg::mmd_rd_t           rd          // data read answer
);
   // ----------------------------------------------------------------
   // decode helper
   // ----------------------------------------------------------------
   function automatic mmd_pkg::mmd_dec_t map_addr(input logic [7:0] a);
      mmd_pkg::mmd_dec_t d;
      d.kind = mmd_pkg::MMD_NONE;
      d.idx  = 7'h00;
      if (a[6:0] < mmd_pkg::SFR_SPAN) begin
         d.kind = mmd_pkg::MMD_SFR;
         d.idx  = a[6:0];
      end else if (!a[7] || a >= mmd_pkg::MIRROR_LO) begin
         // mirror shares the bank 0 formula: F0h-FFh lands on 70h-7Fh
         d.kind = mmd_pkg::MMD_GPR;
         d.idx  = a[6:0] - mmd_pkg::GPR0_BASE;
      end else if (a <= mmd_pkg::GPR1_HI) begin
         d.kind = mmd_pkg::MMD_GPR;
         d.idx  = a[6:0] + mmd_pkg::GPR1_OFS;
      end
      return d;
   endfunction : map_addr

   // ----------------------------------------------------------------
   // program counter and fetch
   // ----------------------------------------------------------------
   logic [13:0] prog_mem [PROG_WORDS];
   logic [10:0] pc_word;

   // upper counter bits are dropped, so any fetch wraps into the store
   assign pc_word = pc[10:0];

   always_ff @(posedge clk) begin
      if (reset) begin
         pc <= mmd_pkg::RESET_VEC;
      end else if (int_take) begin
         pc <= mmd_pkg::INT_VEC;
      end else if (pc_jump) begin
         pc <= pc_target;
      end else if (pc_step) begin
         pc <= pc + 13'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (pgm_we) begin
         prog_mem[pgm_addr] <= pgm_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         instr     <= mmd_pkg::INSN_RST;
         prog_addr <= 11'h000;
      end else begin
         instr     <= prog_mem[pc_word];
         prog_addr <= pc_word;
      end
   end

   // ----------------------------------------------------------------
   // data address resolution
   // ----------------------------------------------------------------
   logic [7:0]        eff_addr;
   mmd_pkg::mmd_dec_t cur;
   logic [7:0]        ram [mmd_pkg::RAM_WORDS];

   // reserved status bits are not decoded; the page stays at 0 and 1
   always_comb begin
      if (req.indirect) begin
         eff_addr = indirect_address_pointer;
      end else begin
         eff_addr = {bank_select_bit, req.dir_addr};
      end
      cur = map_addr(eff_addr);
   end

   always_ff @(posedge clk) begin
      if (req.valid && req.we && cur.kind == mmd_pkg::MMD_GPR) begin
         ram[cur.idx] <= req.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         data_addr <= 8'h00;
      end else if (req.valid) begin
         data_addr <= eff_addr;
      end
   end

   // ----------------------------------------------------------------
   // special register strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         special_function_regs <= '0;
      end else begin
         special_function_regs.sel   <= req.valid && cur.kind == mmd_pkg::MMD_SFR;
         special_function_regs.we    <= req.valid && req.we;
         special_function_regs.addr  <= eff_addr;
         special_function_regs.wdata <= req.wdata;
      end
   end

   // ----------------------------------------------------------------
   // read answer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         rd <= '0;
      end else begin
         rd.valid <= req.valid && !req.we;
         rd.special_function_regs   <= cur.kind == mmd_pkg::MMD_SFR;
         // special data is returned by its own owner, not through here
         if (cur.kind == mmd_pkg::MMD_GPR) begin
            rd.data <= ram[cur.idx];
         end else begin
            rd.data <= mmd_pkg::RDATA_RST;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic [7:0] wdata_w;
   assign wdata_w = req.wdata;

   a_reset_vector: assert property (
      @(posedge clk) disable iff (1'b0)
      reset |=> pc == 13'h0000)
      else $error("pc not at zero after reset");

   a_int_vector: assert property (int_take |=> pc == 13'h0004)
      else $error("interrupt did not load vector");

   a_pc_rollover: assert property (
      pc == 13'h1FFF && pc_step && !pc_jump && !int_take
      |=> pc == 13'h0000)
      else $error("counter width wrong");

   a_prog_backed: assert property (
      pgm_we ##1 (pc_word == $past(pgm_addr) && !pgm_we)
      |=> instr == $past(pgm_wdata, 2))
      else $error("stored word not fetched");

   a_fetch_wrap: assert property (
      (pc[12:11] != 2'b00 && !pgm_we)
      |=> instr == prog_mem[$past(pc_word)])
      else $error("high fetch did not wrap");

   a_sfr_low32: assert property (
      req.valid && eff_addr[6:0] < 7'h20
      |=> special_function_regs.sel && !rd.data[0] && special_function_regs.addr[6:0] < 7'h20)
      else $error("low locations not sent to specials");

   a_sfr_bank1: assert property (
      req.valid && !req.indirect && bank_select_bit
      && req.dir_addr < 7'h20 |=> special_function_regs.sel && special_function_regs.addr[7])
      else $error("bank 1 special not decoded");

   a_gpr_roundtrip: assert property (
      (req.valid && req.we && eff_addr inside {[8'hA0:8'hBF]})
      ##1 (req.valid && !req.we && eff_addr == $past(eff_addr))
      |=> rd.valid && rd.data == $past(wdata_w, 2))
      else $error("bank 1 RAM lost data");

   a_mirror_cells: assert property (
      (req.valid && req.we && eff_addr >= 8'hF0)
      ##1 (req.valid && !req.we
           && eff_addr == $past(eff_addr) - 8'h80)
      |=> rd.data == $past(wdata_w, 2))
      else $error("mirror does not share cells");

   a_unimpl_zero: assert property (
      req.valid && !req.we && eff_addr inside {[8'hC0:8'hEF]}
      |=> rd.valid && rd.data == 8'h00 && !special_function_regs.sel)
      else $error("unimplemented read not zero");

   a_bank_direct: assert property (
      req.valid && !req.indirect
      |=> data_addr[7] == $past(bank_select_bit))
      else $error("bank bit not applied");

   a_direct_form: assert property (
      req.valid && !req.indirect
      |=> data_addr[6:0] == $past(req.dir_addr))
      else $error("direct field misplaced");

   a_indirect_ptr: assert property (
      req.valid && req.indirect
      |=> data_addr == $past(indirect_address_pointer))
      else $error("pointer not used");

   // ----------------------------------------------------------------
   // counter, strobe and answer checks
   // ----------------------------------------------------------------
   a_pc_jump_load: assert property (
      pc_jump && !int_take |=> pc == $past(pc_target))
      else $error("jump target not loaded");

   a_pc_step_inc: assert property (
      pc_step && !pc_jump && !int_take |=> pc == $past(pc) + 13'h0001)
      else $error("step did not advance by one");

   a_pc_hold_idle: assert property (
      !pc_step && !pc_jump && !int_take |=> pc == $past(pc))
      else $error("counter moved without a request");

   // fetch address must follow the low counter bits on every cycle
   a_prog_addr_wrap: assert property (
      1'b1 |=> prog_addr == $past(pc[10:0]))
      else $error("fetch address not wrapped");

   a_rd_pulse_idle: assert property (
      !req.valid |=> !rd.valid)
      else $error("read answer without request");

   a_sel_pulse_idle: assert property (
      !req.valid |=> !special_function_regs.sel)
      else $error("special strobe without request");

   a_rd_write_quiet: assert property (
      req.valid && req.we |=> !rd.valid)
      else $error("write gave a read answer");

   a_gpr_not_sfr: assert property (
      req.valid && eff_addr[6:0] >= 7'h20 |=> !special_function_regs.sel && !rd.special_function_regs)
      else $error("upper location sent to specials");

   a_sfr_zero_data: assert property (
      req.valid && eff_addr[6:0] < 7'h20 |=> rd.special_function_regs && rd.data == 8'h00)
      else $error("special read not flagged or not zero");

   a_gpr_bank0_rt: assert property (
      (req.valid && req.we && !eff_addr[7] && eff_addr[6:0] >= 7'h20)
      ##1 (req.valid && !req.we && eff_addr == $past(eff_addr))
      |=> rd.data == $past(wdata_w, 2))
      else $error("bank 0 RAM lost data");

   a_sfr_fields: assert property (
      req.valid
      |=> special_function_regs.addr == $past(eff_addr) && special_function_regs.wdata == $past(wdata_w))
      else $error("special address or data wrong");

   a_bank1_gpr_dir: assert property (
      req.valid && !req.indirect && bank_select_bit
      && req.dir_addr inside {[7'h20:7'h3F]} |=> !special_function_regs.sel && data_addr[7])
      else $error("bank 1 RAM not selected");

   c_interrupt: cover property (pc_step ##1 int_take ##1 pc == 13'h0004);
   c_mirror: cover property (req.valid && eff_addr >= 8'hF0 ##1 rd.valid);
   c_sfr_write: cover property (req.valid && req.we ##1 special_function_regs.sel);
   c_wrap_fetch: cover property (pc[12:11] == 2'b11);
endmodule : mmd_decoder

// ==== sim/tb_top.sv ====
// self-checking bench for the memory map decoder
`timescale 1ns/10ps
module tb_top;
   logic                clk;
   logic                reset;
   logic                pc_step;
   logic                pc_jump;
   logic [12:0]         pc_target;
   logic                int_take;
   logic                pgm_we;
   logic [10:0]         pgm_addr;
   logic [13:0]         pgm_wdata;
   mmd_pkg::mmd_req_t   req;
   logic                bank_select_bit;
   logic [7:0]          indirect_address_pointer;
   logic [12:0]         pc;
   logic [10:0]         prog_addr;
   logic [13:0]         instr;
   logic [7:0]          data_addr;
   mmd_pkg::mmd_sfr_t   special_function_regs;
   mmd_pkg::mmd_rd_t    rd;
   int                  num_errors;
   int                  comparisons;

   mmd_decoder mmd_decoder_inst (
      .clk                      (clk),
      .reset                    (reset),
      .pc_step                  (pc_step),
      .pc_jump                  (pc_jump),
      .pc_target                (pc_target),
      .int_take                 (int_take),
      .pgm_we                   (pgm_we),
      .pgm_addr                 (pgm_addr),
      .pgm_wdata                (pgm_wdata),
      .req                      (req),
      .bank_select_bit          (bank_select_bit),
      .upper_bank_bit           (1'b0),
      .indirect_page_bit        (1'b0),
      .indirect_address_pointer (indirect_address_pointer),
      .pc                       (pc),
      .prog_addr                (prog_addr),
      .instr                    (instr),
      .data_addr                (data_addr),
      .special_function_regs                      (special_function_regs),
      .rd                       (rd)
   );

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task automatic test_done();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick

   task automatic jump_fetch(logic [12:0] t);
      pc_jump   = 1'b1;
      pc_target = t;
      tick();
      pc_jump = 1'b0;
      tick();
   endtask : jump_fetch

   // request held until the next call or idle(); answer checked after
   task automatic acc(logic we, logic ind, logic bank, logic [6:0] dir,
                      logic [7:0] wd);
      req             = '{valid:1'b1, we:we, indirect:ind,
                          dir_addr:dir, wdata:wd};
      bank_select_bit = bank;
      tick();
   endtask : acc

   task automatic idle();
      req.valid = 1'b0;
      tick();
   endtask : idle

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      check("pc", pc, 0);
      check("instr", instr, 0);
      check("rd", rd, 0);
      check("sfr", special_function_regs, 0);
   endtask : t_reset

   task automatic t_pc();
      jump_fetch(13'h1FFF);
      pc_step = 1'b1;
      tick();
      pc_step = 1'b0;
      check("pc wrap", pc, 0);
      pc_jump   = 1'b1;
      pc_target = 13'h0100;
      int_take  = 1'b1;
      tick();
      pc_jump  = 1'b0;
      int_take = 1'b0;
      check("pc int", pc, 13'h0004);
      reset = 1'b1;
      tick();
      reset = 1'b0;
      check("pc reset", pc, 0);
   endtask : t_pc

   task automatic t_fetch();
      pgm_we    = 1'b1;
      pgm_addr  = 11'h005;
      pgm_wdata = 14'h2ABC;
      tick();
      pgm_addr  = 11'h7FF;
      pgm_wdata = 14'h1555;
      tick();
      pgm_we = 1'b0;
      jump_fetch(13'h0805);
      check("fetch addr", prog_addr, 11'h005);
      check("fetch word", instr, 14'h2ABC);
      jump_fetch(13'h17FF);
      check("top addr", prog_addr, 11'h7FF);
      check("top word", instr, 14'h1555);
      jump_fetch(13'h0005);
      check("low word", instr, 14'h2ABC);
   endtask : t_fetch

   task automatic t_data();
      acc(1'b1, 1'b0, 1'b0, 7'h21, 8'h5A);
      acc(1'b0, 1'b0, 1'b0, 7'h21, 8'h00);
      check("rd", rd, {1'b1, 1'b0, 8'h5A});
      check("addr", data_addr, 8'h21);
      indirect_address_pointer = 8'h21;
      acc(1'b0, 1'b1, 1'b1, 7'h00, 8'h00);
      check("ind rd", rd.data, 8'h5A);
      check("ind addr", data_addr, 8'h21);
      acc(1'b1, 1'b0, 1'b1, 7'h20, 8'hC3);
      acc(1'b1, 1'b0, 1'b0, 7'h20, 8'h11);
      acc(1'b0, 1'b0, 1'b1, 7'h20, 8'h00);
      check("bank1 rd", rd.data, 8'hC3);
      check("bank1 addr", data_addr, 8'hA0);
      acc(1'b1, 1'b0, 1'b0, 7'h75, 8'h77);
      acc(1'b0, 1'b0, 1'b1, 7'h75, 8'h00);
      check("mirror rd", rd.data, 8'h77);
      check("mirror addr", data_addr, 8'hF5);
      acc(1'b1, 1'b0, 1'b1, 7'h7E, 8'h99);
      acc(1'b0, 1'b0, 1'b0, 7'h7E, 8'h00);
      check("mirror wr", rd.data, 8'h99);
      acc(1'b1, 1'b0, 1'b1, 7'h45, 8'hFF);
      acc(1'b0, 1'b0, 1'b1, 7'h45, 8'h00);
      check("unimpl rd", rd, {1'b1, 1'b0, 8'h00});
      acc(1'b1, 1'b0, 1'b1, 7'h03, 8'h42);
      check("sfr wr", special_function_regs, {1'b1, 1'b1, 8'h83, 8'h42});
      acc(1'b0, 1'b0, 1'b0, 7'h1F, 8'h00);
      check("sfr sel", special_function_regs.sel, 1'b1);
      check("sfr addr", special_function_regs.addr, 8'h1F);
      check("sfr rd", rd, {1'b1, 1'b1, 8'h00});
      idle();
      check("sel pulse", special_function_regs.sel, 1'b0);
      check("rd pulse", rd.valid, 1'b0);
   endtask : t_data

   // ----------------------------------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      repeat (2000) @(posedge clk);
      num_errors++;
      test_done();
   end

   initial begin
      num_errors               = 0;
      comparisons              = 0;
      reset                    = 1'b1;
      pc_step                  = 1'b0;
      pc_jump                  = 1'b0;
      pc_target                = 13'h0000;
      int_take                 = 1'b0;
      pgm_we                   = 1'b0;
      pgm_addr                 = 11'h000;
      pgm_wdata                = 14'h0000;
      req                      = '0;
      bank_select_bit          = 1'b0;
      indirect_address_pointer = 8'h00;
      repeat (5) tick();
      reset = 1'b0;
      t_reset();
      t_fetch();
      t_pc();
      t_data();
      test_done();
   end
endmodule : tb_top
